// [rtl/dvol_map.svh]
/*
 * Register map, field positions, reset values and auto-mute timing for the
 * digital volume and auto-mute block.
 * Assumes it is included by bare name from the design files that need it.
 */
`ifndef DVOL_MAP_SVH
`define DVOL_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices; the Avalon byte address is the index shifted left by two.
`define REG_AUTO_MUTE_TIME 8'h3b
`define REG_VOLUME_LINK 8'h3c
`define REG_LEFT_VOLUME 8'h3d
`define REG_RIGHT_VOLUME 8'h3e
`define REG_MUTE_STATUS 8'h50
`define WORD_SHIFT 2

////////////////////////////////////////////////////////////////////////////////
// Reset values.
`define RST_AUTO_MUTE_TIME 8'h00
`define RST_VOLUME_LINK 8'h00
`define RST_LEFT_VOLUME 8'h10
`define RST_RIGHT_VOLUME 8'h30

////////////////////////////////////////////////////////////////////////////////
// Field positions.
`define LEFT_RUN_MSB 6
`define LEFT_RUN_LSB 4
`define RIGHT_RUN_MSB 2
`define RIGHT_RUN_LSB 0
`define LINK_MSB 1
`define LINK_LSB 0
`define STATUS_LEFT_BIT 0
`define STATUS_RIGHT_BIT 1

////////////////////////////////////////////////////////////////////////////////
// Gain code decoding.
`define GAIN_MUTE_CODE 8'hff
`define CODES_PER_OCTAVE 12
`define GAIN_UNITY_SHIFT 12

////////////////////////////////////////////////////////////////////////////////
// Zero-run durations in microseconds at the reference sample rate in kHz.
`define SAMPLE_RATE_KHZ 96
`define AMT_T0_US 11500
`define AMT_T1_US 53000
`define AMT_T2_US 106500
`define AMT_T3_US 266500
`define AMT_T4_US 535000
`define AMT_T5_US 1065000
`define AMT_T6_US 2665000
`define AMT_T7_US 5330000

`endif

// [rtl/dvol_pkg.sv]
/*
 * Types shared by the digital volume and auto-mute design files.
 * Assumes nothing of its surroundings.
 */
package dvol_pkg;

	// Volume linking modes.
	typedef enum logic [1:0] {
		LINK_INDEPENDENT = 2'b00,
		LINK_FOLLOW_LEFT = 2'b01
	} link_mode_t;

	// One 8-bit attenuation code.
	typedef logic [7:0] gain_code_t;

	// Zero-run sample counter; holds the longest run of 511680 samples.
	typedef logic [18:0] run_count_t;

endpackage

// [rtl/sample_fifo.sv]
/*
 * Synchronous FIFO with valid and ready on both sides and registered read data.
 * Assumes one clock, an asynchronous active-high reset and a power-of-two depth.
 */
`timescale 1ns/1ps

module sample_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_reg;
	logic [AW-1:0] rdPtr_reg;
	logic [AW-1:0] rdPtr_next;
	logic [CW-1:0] count_reg;
	logic push;
	logic pop;

	////////////////////////////////////////////////////////////////////////////
	// Handshakes; both close while the clock enable is low.
	assign inReady = ce && (count_reg != CW'(DEPTH));
	assign outValid = ce && (count_reg != '0);
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign rdPtr_next = pop ? AW'(rdPtr_reg + 1'b1) : rdPtr_reg;

	// Storage array written on every accepted word.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	// Pointers and fill count.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else if (ce) begin
			if (push) begin
				wrPtr_reg <= AW'(wrPtr_reg + 1'b1);
			end
			rdPtr_reg <= rdPtr_next;
			count_reg <= CW'(count_reg + CW'(push) - CW'(pop));
		end
	end

	// Head word register; a word written to the new head slot is bypassed.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			outData <= '0;
		end else if (ce) begin
			outData <= (push && wrPtr_reg == rdPtr_next) ? inData : mem[rdPtr_next];
		end
	end

endmodule

// [rtl/digital_volume_auto_mute.sv]
/*
 * Stereo digital volume with per-channel auto-mute on runs of zero samples,
 * reached over an Avalon-MM slave with waitrequest.
 * Assumes one 10 MHz clock, stereo frames from logic on the same clock, and a
 * downstream sink that may stall through outReady.
 */
// Local design decision: the Avalon-MM slave port.
// How it works
// R1 - Left zero-run duration code sits in bits 6 to 4 of the auto-mute register.
// R2 - Right zero-run duration code sits in bits 2 to 0 of that register.
// R3 - Codes map 11.5 ms up to 5.33 s in the eight listed steps.
// R4 - Durations hold at 96 kHz, so each code is a fixed sample count.
// R5 - A non-zero sample restarts the run count and releases auto-mute at once.
// R6 - Link field 00 keeps left and right volume independent.
// R7 - Link field 01 makes the right channel use the left volume code.
// R8 - Left gain code spans +24 dB to -103 dB in 0.5 dB steps.
// R9 - Code 0x00 is +24 dB, 0x30 is 0 dB, 0xfe -103 dB, 0xff mutes.
// R10 - A separate right volume register uses the same gain encoding.
`timescale 1ns/1ps
`include "dvol_map.svh"

module digital_volume_auto_mute #(
	parameter int SAMPLE_WIDTH = 24,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic inValid,
	output logic inReady,
	input wire logic [SAMPLE_WIDTH-1:0] inLeft,
	input wire logic [SAMPLE_WIDTH-1:0] inRight,
	output logic outValid,
	input wire logic outReady,
	output logic [SAMPLE_WIDTH-1:0] outLeft,
	output logic [SAMPLE_WIDTH-1:0] outRight,
	output logic leftAutoMuted,
	output logic rightAutoMuted
);

	localparam int FW = 2 * SAMPLE_WIDTH;
	localparam int PW = SAMPLE_WIDTH + 18;

	////////////////////////////////////////////////////////////////////////////
	// Decoding functions.

	// Turns a duration code into the number of zero samples it stands for.
	function automatic dvol_pkg::run_count_t runLimit(input logic [2:0] code);
		int unsigned us;
		us = `AMT_T0_US;
		case (code)
			3'h0: us = `AMT_T0_US;
			3'h1: us = `AMT_T1_US;
			3'h2: us = `AMT_T2_US;
			3'h3: us = `AMT_T3_US;
			3'h4: us = `AMT_T4_US;
			3'h5: us = `AMT_T5_US;
			3'h6: us = `AMT_T6_US;
			default: us = `AMT_T7_US;
		endcase
		// The duration is fixed in samples, so it scales with the real rate.
		return dvol_pkg::run_count_t'(us * `SAMPLE_RATE_KHZ / 1000); // R3 R4
	endfunction

	// Linear factor of one 0.5 dB step within a 6 dB octave, unity at 17'h10000.
	function automatic logic [16:0] stepFactor(input logic [3:0] step);
		logic [16:0] m;
		m = 17'h10000;
		case (step)
			4'h0: m = 17'h10000;
			4'h1: m = 17'h0f1ae;
			4'h2: m = 17'h0e429;
			4'h3: m = 17'h0d766;
			4'h4: m = 17'h0cb59;
			4'h5: m = 17'h0bff9;
			4'h6: m = 17'h0b53c;
			4'h7: m = 17'h0ab19;
			4'h8: m = 17'h0a186;
			4'h9: m = 17'h0987d;
			4'ha: m = 17'h08ff5;
			4'hb: m = 17'h087e8;
			default: m = 17'h10000;
		endcase
		return m;
	endfunction

	// Scales one sample by a gain code, saturating at full scale.
	function automatic logic [SAMPLE_WIDTH-1:0] applyGain(
		input logic [SAMPLE_WIDTH-1:0] x,
		input dvol_pkg::gain_code_t code
	);
		logic [3:0] step;
		logic [4:0] octave;
		logic signed [PW-1:0] prod;
		logic signed [PW-1:0] scaled;
		logic signed [PW-1:0] hiLim;
		logic signed [PW-1:0] loLim;
		logic [SAMPLE_WIDTH-1:0] y;
		// Each code lowers the gain 0.5 dB; twelve codes make one halving.
		step = 4'(code % `CODES_PER_OCTAVE); // R8
		octave = 5'(code / `CODES_PER_OCTAVE);
		prod = PW'($signed(x) * $signed({1'b0, stepFactor(step)}));
		// Code 0x00 is 16x (+24 dB) and code 0x30 is unity.
		scaled = prod >>> (`GAIN_UNITY_SHIFT + octave); // R9
		hiLim = $signed({{19{1'b0}}, {(SAMPLE_WIDTH - 1){1'b1}}});
		loLim = $signed({{19{1'b1}}, {(SAMPLE_WIDTH - 1){1'b0}}});
		if (code == `GAIN_MUTE_CODE) begin
			y = '0; // R9
		end else if (scaled > hiLim) begin
			y = hiLim[SAMPLE_WIDTH-1:0];
		end else if (scaled < loLim) begin
			y = loLim[SAMPLE_WIDTH-1:0];
		end else begin
			y = scaled[SAMPLE_WIDTH-1:0];
		end
		return y;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register file.

	logic [7:0] autoMuteTime_reg;
	logic [7:0] volumeLink_reg;
	logic [7:0] leftVolume_reg;
	logic [7:0] rightVolume_reg;
	logic ack_reg;
	logic [7:0] index;
	logic doWrite;
	logic [1:0] autoMuted;

	assign index = address[9:`WORD_SHIFT];
	// A request completes in its second enabled cycle; a low enable keeps it waiting.
	assign waitrequest = (read || write) && !(ack_reg && ce);
	assign doWrite = ce && write && ack_reg && byteenable[0];

	// Acknowledge toggles high for the second cycle of each request.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_reg <= 1'b0;
		end else if (ce) begin
			ack_reg <= (read || write) && !ack_reg;
		end
	end

	// Auto-mute duration register; both codes and the spare bits are stored.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			autoMuteTime_reg <= `RST_AUTO_MUTE_TIME;
		end else if (doWrite && index == `REG_AUTO_MUTE_TIME) begin
			autoMuteTime_reg <= writedata[7:0]; // R1 R2
		end
	end

	// Volume linking register.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			volumeLink_reg <= `RST_VOLUME_LINK;
		end else if (doWrite && index == `REG_VOLUME_LINK) begin
			volumeLink_reg <= writedata[7:0];
		end
	end

	// Left and right volume registers.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			leftVolume_reg <= `RST_LEFT_VOLUME;
			rightVolume_reg <= `RST_RIGHT_VOLUME;
		end else if (doWrite) begin
			if (index == `REG_LEFT_VOLUME) begin
				leftVolume_reg <= writedata[7:0]; // R8
			end
			if (index == `REG_RIGHT_VOLUME) begin
				rightVolume_reg <= writedata[7:0]; // R10
			end
		end
	end

	// Read data is captured in the first cycle and stands at the completing edge.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			readdata <= '0;
		end else if (ce && read && !ack_reg) begin
			case (index)
				`REG_AUTO_MUTE_TIME: readdata <= {24'h000000, autoMuteTime_reg};
				`REG_VOLUME_LINK: readdata <= {24'h000000, volumeLink_reg};
				`REG_LEFT_VOLUME: readdata <= {24'h000000, leftVolume_reg};
				`REG_RIGHT_VOLUME: readdata <= {24'h000000, rightVolume_reg};
				`REG_MUTE_STATUS: readdata <= {30'h00000000, autoMuted};
				default: readdata <= 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Effective gain codes.

	dvol_pkg::gain_code_t rightCode;
	dvol_pkg::link_mode_t linkMode;

	assign linkMode = dvol_pkg::link_mode_t'(volumeLink_reg[`LINK_MSB:`LINK_LSB]);

	// The right channel uses its own code unless linked to the left.
	always_comb begin
		case (linkMode)
			dvol_pkg::LINK_INDEPENDENT: rightCode = rightVolume_reg; // R6
			dvol_pkg::LINK_FOLLOW_LEFT: rightCode = leftVolume_reg; // R7
			default: rightCode = rightVolume_reg;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Sample buffer and output stage.

	logic fifoValid;
	logic fifoReady;
	logic [FW-1:0] fifoData;
	logic drain;
	logic outValid_reg;
	logic [SAMPLE_WIDTH-1:0] chSample [2];
	logic [SAMPLE_WIDTH-1:0] chResult [2];
	dvol_pkg::gain_code_t chCode [2];
	dvol_pkg::run_count_t chLimit [2];

	sample_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.inValid(inValid),
		.inReady(inReady),
		.inData({inLeft, inRight}),
		.outValid(fifoValid),
		.outReady(fifoReady),
		.outData(fifoData)
	);

	// The buffer drains only while the output stage is empty or being taken.
	assign fifoReady = !outValid_reg || outReady;
	assign drain = fifoValid && fifoReady;
	assign outValid = outValid_reg;

	assign chSample[0] = fifoData[FW-1:SAMPLE_WIDTH];
	assign chSample[1] = fifoData[SAMPLE_WIDTH-1:0];
	assign chCode[0] = leftVolume_reg;
	assign chCode[1] = rightCode;
	assign chLimit[0] = runLimit(autoMuteTime_reg[`LEFT_RUN_MSB:`LEFT_RUN_LSB]); // R1
	assign chLimit[1] = runLimit(autoMuteTime_reg[`RIGHT_RUN_MSB:`RIGHT_RUN_LSB]); // R2

	// Per-channel zero-run counter, auto-mute flag and gain stage.
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		dvol_pkg::run_count_t runCount_reg;
		dvol_pkg::run_count_t runCount_next;
		logic autoMute_reg;
		logic isZero;
		logic muteNow;

		assign isZero = (chSample[ch] == '0);
		assign runCount_next = isZero ? dvol_pkg::run_count_t'(runCount_reg + 1'b1) : '0;
		assign muteNow = isZero && (runCount_next >= chLimit[ch]);

		// Counts zero samples, saturating at the limit.
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				runCount_reg <= '0;
				autoMute_reg <= 1'b0;
			end else if (ce && drain) begin
				if (!isZero) begin
					runCount_reg <= '0; // R5
					autoMute_reg <= 1'b0; // R5
				end else begin
					if (runCount_reg < chLimit[ch]) begin
						runCount_reg <= runCount_next; // R4
					end
					autoMute_reg <= muteNow;
				end
			end
		end

		assign autoMuted[ch] = autoMute_reg;
		assign chResult[ch] = muteNow ? '0 : applyGain(chSample[ch], chCode[ch]);
	end

	// Output stage holds one gained frame until the sink takes it.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			outValid_reg <= 1'b0;
			outLeft <= '0;
			outRight <= '0;
		end else if (ce) begin
			if (drain) begin
				outValid_reg <= 1'b1;
				outLeft <= chResult[0];
				outRight <= chResult[1];
			end else if (outReady) begin
				outValid_reg <= 1'b0;
			end
		end
	end

	assign leftAutoMuted = autoMuted[`STATUS_LEFT_BIT];
	assign rightAutoMuted = autoMuted[`STATUS_RIGHT_BIT];

endmodule

// [tb/dvol_assertions.sv]
/*
 * Port checker for the volume and auto-mute block.
 * Assumes the top module's ports and one clock.
 */
`timescale 1ns/1ps

module dvol_assertions #(
	parameter int SAMPLE_WIDTH = 24,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic inValid,
	input wire logic inReady,
	input wire logic outValid,
	input wire logic outReady,
	input wire logic [SAMPLE_WIDTH-1:0] outLeft,
	input wire logic [SAMPLE_WIDTH-1:0] outRight,
	input wire logic leftAutoMuted,
	input wire logic rightAutoMuted
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic mapped;

	////////////////////////////////////////////////////////////////////////
	// Marks register indices that hold a register.
	assign mapped = address[9:2] inside {8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h50};

	////////////////////////////////////////////////////////////////////////
	// Bus, stream and auto-mute relations.
	a_wait_first: assert property ((read || write) && !$past(read || write) |-> waitrequest)
		else $error("waitrequest low on first request cycle");
	a_wait_one: assert property ((read || write) && waitrequest && ce |=> !waitrequest)
		else $error("waitrequest held too long");
	a_idle_nowait: assert property (!(read || write) |-> !waitrequest)
		else $error("waitrequest without request");
	a_unmapped_zero: assert property (read && !waitrequest && !mapped |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	a_out_hold: assert property (outValid && !outReady |=>
		outValid && $stable(outLeft) && $stable(outRight))
		else $error("output changed while stalled");
	a_push_path: assert property (inValid && inReady && !outValid |-> ##[1:4] outValid)
		else $error("pushed frame did not appear");
	a_left_mute: assert property (leftAutoMuted && outValid |-> outLeft == '0)
		else $error("left muted but not zero");
	a_right_mute: assert property (rightAutoMuted && outValid |-> outRight == '0)
		else $error("right muted but not zero");
	a_left_release: assert property (outValid && outLeft != '0 |-> !leftAutoMuted)
		else $error("left flag with nonzero data");
	c_left_mute: cover property ($rose(leftAutoMuted));
	c_right_mute: cover property ($rose(rightAutoMuted));
	c_stall: cover property (outValid && !outReady && !inReady);
endmodule

bind digital_volume_auto_mute dvol_assertions #(.SAMPLE_WIDTH(SAMPLE_WIDTH),
	.FIFO_DEPTH(FIFO_DEPTH)) chk (.sys_clk, .rst, .ce, .address, .read, .write,
	.readdata, .waitrequest, .inValid, .inReady, .outValid, .outReady, .outLeft,
	.outRight, .leftAutoMuted, .rightAutoMuted);

// [tb/testbench.sv]
/*
 * Self-checking bench: registers, gain, linking, buffering, auto-mute.
 * Assumes the design files are compiled first.
 */
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end

module testbench;
	logic sys_clk = 0, rst = 1, ce = 1, read = 0, write = 0, inValid = 0, outReady = 0;
	logic [9:0] address = 0;
	logic [31:0] writedata = 0, readdata, q;
	logic [3:0] byteenable = 4'hf;
	logic [23:0] inLeft = 0, inRight = 0, outLeft, outRight;
	logic waitrequest, inReady, outValid, leftAutoMuted, rightAutoMuted, stall = 0;
	logic [7:0] lCode = 8'h10, rCode = 8'h30, link = 0, amt = 0;
	logic [7:0] g[5] = '{8'h30, 8'h3c, 8'h24, 8'hff, 8'h00};
	logic [49:0] expQ[$], e;
	int lim[8] = '{1104, 5088, 10224, 25584, 51360, 102240, 255840, 511680};
	int mismatches = 0, n_compared = 0, cycles = 0, lRun = 0, rRun = 0, n;

	digital_volume_auto_mute uut (.sys_clk, .rst, .ce, .address, .read, .write,
		.writedata, .byteenable, .readdata, .waitrequest, .inValid, .inReady, .inLeft,
		.inRight, .outValid, .outReady, .outLeft, .outRight, .leftAutoMuted,
		.rightAutoMuted);

	////////////////////////////////////////////////////////////////////////
	// Clock, random sink stalls and hang guard.
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		outReady <= !stall && $urandom_range(3) != 0;
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			summarize();
		end
	end

	// Scoreboard: gained samples and a zero-run model per channel.
	always @(posedge sys_clk) begin
		if (!rst && outValid && outReady) begin
			e = expQ.pop_front();
			lRun = e[49] ? lRun + 1 : 0;
			rRun = e[48] ? rRun + 1 : 0;
			`CHECK("outLeft", e[47:24], outLeft)
			`CHECK("outRight", e[23:0], outRight)
			`CHECK("leftMuted", lRun >= lim[amt[6:4]], leftAutoMuted)
			`CHECK("rightMuted", rRun >= lim[amt[2:0]], rightAutoMuted)
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Expected gain for the codes the bench uses.
	function automatic logic [23:0] gain(logic [23:0] x, logic [7:0] c);
		case (c)
			8'h30: return x;
			8'h3c: return {x[23], x[23:1]};
			8'h24: return {x[22:0], 1'b0};
			8'h00: return {x[19:0], 4'h0};
			default: return 24'h0;
		endcase
	endfunction

	// Random even sample well inside range.
	function automatic logic [23:0] rs();
		logic [31:0] u;
		u = $urandom;
		return {{4{u[19]}}, u[19:1], 1'b0};
	endfunction

	// One Avalon transfer, held until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
		address <= {i, 2'b00};
		read <= !w;
		write <= w;
		writedata <= {24'h0, d};
		do @(posedge sys_clk); while (waitrequest);
		q = readdata;
		read <= 0;
		write <= 0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] i, input logic [7:0] d);
		bus(0, i, 0);
		`CHECK("readdata", {24'h0, d}, q)
	endtask

	// Pushes one frame and records what should come out.
	task automatic push(input logic [23:0] l, input logic [23:0] r);
		inLeft <= l;
		inRight <= r;
		inValid <= 1;
		do @(posedge sys_clk); while (!inReady);
		expQ.push_back({l == 0, r == 0, gain(l, lCode), gain(r, link == 1 ? lCode : rCode)});
	endtask

	task automatic drain();
		inValid <= 0;
		while (expQ.size() != 0) @(posedge sys_clk);
		@(posedge sys_clk);
	endtask

	task automatic summarize();
		if (mismatches == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		void'($urandom(91727));
		repeat (2) @(posedge sys_clk);
		rst <= 0;
		@(posedge sys_clk);
		rd(8'h3b, 0);
		rd(8'h3c, 0);
		rd(8'h3d, 8'h10);
		rd(8'h3e, 8'h30);
		rd(8'h40, 0);
		for (int i = 8'h3b; i <= 8'h3e; i++) begin
			n = $urandom;
			bus(1, 8'(i), 8'(n));
			rd(8'(i), 8'(n));
		end
		byteenable <= 4'he;
		bus(1, 8'h3e, ~8'(n));
		byteenable <= 4'hf;
		rd(8'h3e, 8'(n));
		bus(1, 8'h40, 8'hff);
		rd(8'h40, 0);
		bus(1, 8'h3b, 8'h77);
		amt = 8'h77;
		for (int a = 0; a < 5; a++) begin
			for (int k = 0; k < 3; k++) begin
				lCode = g[a];
				rCode = g[4 - a];
				link = 8'(k);
				bus(1, 8'h3d, lCode);
				bus(1, 8'h3e, rCode);
				bus(1, 8'h3c, link);
				repeat (6) push(rs(), rs());
				drain();
			end
		end
		lCode = 8'h30;
		bus(1, 8'h3d, lCode);
		stall = 1;
		n = 0;
		inLeft <= 24'h000abc;
		inRight <= 24'hfff002;
		inValid <= 1;
		repeat (30) begin
			@(posedge sys_clk);
			if (inReady) begin
				n++;
				expQ.push_back({2'b00, 24'h000abc, 24'hfff002});
			end
		end
		`CHECK("fill", 17, n)
		stall = 0;
		drain();
		for (int k = 0; k < 2; k++) begin
			amt = k ? 8'h10 : 8'h01;
			bus(1, 8'h3b, amt);
			repeat (1110) push(0, 0);
			drain();
			rd(8'h50, k ? 8'h02 : 8'h01);
			push(rs() | 24'h2, rs() | 24'h2);
			drain();
		end
		summarize();
	end
endmodule
